// ===== shared/pps_defines.svh
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPS_OFS_IN_AB     8'h00
`define PPS_OFS_CMOS_DATA 8'h04
`define PPS_OFS_CMOS_DIR  8'h08
`define PPS_OFS_OD_DATA   8'h0C
`define PPS_OFS_OD_DIR    8'h10
`define PPS_OFS_BIT_OUT   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPS_DIR_C_BIT     0
`define PPS_DIR_H_BIT     1
`define PPS_DIR_E_BIT     0
`define PPS_DIR_F_BIT     1
`define PPS_SEG_SEL_BIT   8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPS_RST_NIB       4'h0
`define PPS_RST_BYTE      8'h00
`define PPS_RST_DIR       1'b0
`define PPS_RST_WORD      32'h0000_0000

`endif

// ===== shared/pps_pkg.sv
package pps_pkg;

    // Bus answer sequencer, one-hot
    typedef enum logic [1:0] {
        PPS_ST_IDLE = 2'b01,
        PPS_ST_ACK  = 2'b10
    } pps_bus_state_t;

    typedef logic [3:0] pps_nib_t;

endpackage : pps_pkg

// ===== src/pps_nibble_cell.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One 4-line port: drive, enable and readback
// ----------------------------------------------------------------
module pps_nibble_cell
    import pps_pkg::*;
#(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire pps_nib_t dat,
    input wire pps_nib_t dir,
    input wire pps_nib_t pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [3:0] rd_val
);

    // Open drain only pulls low; a high latch bit releases the pin
    always_comb begin
        if (OPEN_DRAIN) begin
            pin_out = 4'h0;
            pin_oe = dir & ~dat;
        end else begin
            pin_out = dat;
            pin_oe = dir;
        end
        // Output lines read the latch, input lines the pin
        rd_val = (dir & dat) | (~dir & pin_in);
    end

endmodule : pps_nibble_cell

// ===== src/pps_port_set.sv
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_port_set
    import pps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] input_nibble_a_in,
    input wire logic [3:0] input_nibble_b_in,
    input wire logic [3:0] io_nibble_c_in,
    output logic [3:0] io_nibble_c_out,
    output logic [3:0] io_nibble_c_oe,
    input wire logic [3:0] io_bitwise_d_in,
    output logic [3:0] io_bitwise_d_out,
    output logic [3:0] io_bitwise_d_oe,
    input wire logic [3:0] io_bitwise_g_in,
    output logic [3:0] io_bitwise_g_out,
    output logic [3:0] io_bitwise_g_oe,
    input wire logic [3:0] io_nibble_h_in,
    output logic [3:0] io_nibble_h_out,
    output logic [3:0] io_nibble_h_oe,
    input wire logic [3:0] opendrain_nibble_e_in,
    output logic [3:0] opendrain_nibble_e_out,
    output logic [3:0] opendrain_nibble_e_oe,
    input wire logic [3:0] opendrain_nibble_f_in,
    output logic [3:0] opendrain_nibble_f_out,
    output logic [3:0] opendrain_nibble_f_oe,
    input wire logic [7:0] seg_data_in,
    output logic [7:0] upper_segment_pins
);

    // ----------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------
    pps_bus_state_t st_r, st_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic req, commit;
    logic [31:0] rd_mux;

    // One wait state: the answer always comes at the second edge
    always_comb begin
        req = avs_read | avs_write;
        st_nxt = st_r;
        rdata_nxt = rdata_r;
        unique case (st_r)
            PPS_ST_IDLE: begin
                if (req) begin
                    st_nxt = PPS_ST_ACK;
                    rdata_nxt = avs_read ? rd_mux : `PPS_RST_WORD;
                end
            end
            PPS_ST_ACK: begin
                st_nxt = PPS_ST_IDLE;
            end
        endcase
        commit = avs_write && (st_r == PPS_ST_ACK);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= PPS_ST_IDLE;
            rdata_r <= `PPS_RST_WORD;
        end else begin
            st_r <= st_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest = req && (st_r != PPS_ST_ACK);
    assign avs_readdata = rdata_r;

    // ----------------------------------------------------------------
    // Port latches and direction
    // ----------------------------------------------------------------
    pps_nib_t c_r, d_r, g_r, h_r, e_r, f_r;
    pps_nib_t c_nxt, d_nxt, g_nxt, h_nxt, e_nxt, f_nxt;
    pps_nib_t d_dir_r, g_dir_r, d_dir_nxt, g_dir_nxt;
    logic c_dir_r, h_dir_r, e_dir_r, f_dir_r;
    logic c_dir_nxt, h_dir_nxt, e_dir_nxt, f_dir_nxt;
    logic [7:0] bits_r, bits_nxt;
    logic seg_sel_r, seg_sel_nxt;
    logic [3:0] be;

    // Writes land only at the edge where waitrequest is low
    always_comb begin
        be = avs_byteenable;
        {c_nxt, d_nxt, g_nxt, h_nxt, e_nxt, f_nxt} = {c_r, d_r, g_r, h_r, e_r, f_r};
        {d_dir_nxt, g_dir_nxt} = {d_dir_r, g_dir_r};
        {c_dir_nxt, h_dir_nxt, e_dir_nxt, f_dir_nxt} = {c_dir_r, h_dir_r, e_dir_r, f_dir_r};
        bits_nxt = bits_r;
        seg_sel_nxt = seg_sel_r;
        if (commit) begin
            unique case (avs_address)
                `PPS_OFS_CMOS_DATA: begin
                    if (be[0]) {d_nxt, c_nxt} = avs_writedata[7:0];
                    if (be[1]) {h_nxt, g_nxt} = avs_writedata[15:8];
                end
                `PPS_OFS_CMOS_DIR: begin
                    if (be[0]) begin
                        c_dir_nxt = avs_writedata[`PPS_DIR_C_BIT];
                        h_dir_nxt = avs_writedata[`PPS_DIR_H_BIT];
                    end
                    if (be[1]) {g_dir_nxt, d_dir_nxt} = avs_writedata[15:8];
                end
                `PPS_OFS_OD_DATA: begin
                    if (be[0]) {f_nxt, e_nxt} = avs_writedata[7:0];
                end
                `PPS_OFS_OD_DIR: begin
                    if (be[0]) begin
                        e_dir_nxt = avs_writedata[`PPS_DIR_E_BIT];
                        f_dir_nxt = avs_writedata[`PPS_DIR_F_BIT];
                    end
                end
                `PPS_OFS_BIT_OUT: begin
                    if (be[0]) bits_nxt = avs_writedata[7:0];
                    if (be[1]) seg_sel_nxt = avs_writedata[`PPS_SEG_SEL_BIT];
                end
                default: begin
                    // Input port and unmapped words ignore writes
                end
            endcase
        end
    end

    // All directions clear to input at reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {c_r, d_r, g_r, h_r} <= {4{`PPS_RST_NIB}};
            {e_r, f_r} <= {2{`PPS_RST_NIB}};
            {d_dir_r, g_dir_r} <= {2{`PPS_RST_NIB}};
            {c_dir_r, h_dir_r, e_dir_r, f_dir_r} <= {4{`PPS_RST_DIR}};
            bits_r <= `PPS_RST_BYTE;
            seg_sel_r <= `PPS_RST_DIR;
        end else begin
            {c_r, d_r, g_r, h_r} <= {c_nxt, d_nxt, g_nxt, h_nxt};
            {e_r, f_r} <= {e_nxt, f_nxt};
            {d_dir_r, g_dir_r} <= {d_dir_nxt, g_dir_nxt};
            {c_dir_r, h_dir_r, e_dir_r, f_dir_r} <= {c_dir_nxt, h_dir_nxt, e_dir_nxt, f_dir_nxt};
            bits_r <= bits_nxt;
            seg_sel_r <= seg_sel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Line cells
    // ----------------------------------------------------------------
    logic [3:0] rd_c, rd_d, rd_g, rd_h, rd_e, rd_f;

    // Nibble ports fan one direction bit to all four lines
    pps_nibble_cell #(.OPEN_DRAIN(1'b0)) u_c (.dat(c_r), .dir({4{c_dir_r}}),
        .pin_in(io_nibble_c_in), .pin_out(io_nibble_c_out), .pin_oe(io_nibble_c_oe),
        .rd_val(rd_c));
    pps_nibble_cell #(.OPEN_DRAIN(1'b0)) u_d (.dat(d_r), .dir(d_dir_r),
        .pin_in(io_bitwise_d_in), .pin_out(io_bitwise_d_out), .pin_oe(io_bitwise_d_oe),
        .rd_val(rd_d));
    pps_nibble_cell #(.OPEN_DRAIN(1'b0)) u_g (.dat(g_r), .dir(g_dir_r),
        .pin_in(io_bitwise_g_in), .pin_out(io_bitwise_g_out), .pin_oe(io_bitwise_g_oe),
        .rd_val(rd_g));
    pps_nibble_cell #(.OPEN_DRAIN(1'b0)) u_h (.dat(h_r), .dir({4{h_dir_r}}),
        .pin_in(io_nibble_h_in), .pin_out(io_nibble_h_out), .pin_oe(io_nibble_h_oe),
        .rd_val(rd_h));
    pps_nibble_cell #(.OPEN_DRAIN(1'b1)) u_e (.dat(e_r), .dir({4{e_dir_r}}),
        .pin_in(opendrain_nibble_e_in), .pin_out(opendrain_nibble_e_out),
        .pin_oe(opendrain_nibble_e_oe), .rd_val(rd_e));
    pps_nibble_cell #(.OPEN_DRAIN(1'b1)) u_f (.dat(f_r), .dir({4{f_dir_r}}),
        .pin_in(opendrain_nibble_f_in), .pin_out(opendrain_nibble_f_out),
        .pin_oe(opendrain_nibble_f_oe), .rd_val(rd_f));

    // Segment drive takes the upper pins when selected
    assign upper_segment_pins = seg_sel_r ? seg_data_in : bits_r;

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // Input ports have no direction or latch; pins always read back
    always_comb begin
        rd_mux = `PPS_RST_WORD;
        unique case (avs_address)
            `PPS_OFS_IN_AB: rd_mux[7:0] = {input_nibble_b_in, input_nibble_a_in};
            `PPS_OFS_CMOS_DATA: rd_mux[15:0] = {rd_h, rd_g, rd_d, rd_c};
            `PPS_OFS_CMOS_DIR: begin
                rd_mux[`PPS_DIR_C_BIT] = c_dir_r;
                rd_mux[`PPS_DIR_H_BIT] = h_dir_r;
                rd_mux[15:8] = {g_dir_r, d_dir_r};
            end
            `PPS_OFS_OD_DATA: rd_mux[7:0] = {rd_f, rd_e};
            `PPS_OFS_OD_DIR: begin
                rd_mux[`PPS_DIR_E_BIT] = e_dir_r;
                rd_mux[`PPS_DIR_F_BIT] = f_dir_r;
            end
            `PPS_OFS_BIT_OUT: begin
                rd_mux[7:0] = bits_r;
                rd_mux[`PPS_SEG_SEL_BIT] = seg_sel_r;
            end
            default: rd_mux = `PPS_RST_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_take(logic [7:0] ofs);
        st_r == PPS_ST_IDLE && avs_address == ofs;
    endsequence

    sequence s_wr_done(logic [7:0] ofs);
        avs_write && st_r == PPS_ST_ACK && avs_address == ofs;
    endsequence

    AST_IN_READ: assert property (s_take(`PPS_OFS_IN_AB) and avs_read |=>
        avs_readdata[7:0] == $past({input_nibble_b_in, input_nibble_a_in}) && !avs_waitrequest)
        else $error("input port read mismatch");
    AST_NIB_DIR: assert property ((io_nibble_c_oe == 4'h0 || io_nibble_c_oe == 4'hF) &&
        (io_nibble_h_oe == 4'h0 || io_nibble_h_oe == 4'hF))
        else $error("nibble port direction split");
    AST_PAIR_WR: assert property (s_wr_done(`PPS_OFS_CMOS_DATA) and avs_byteenable[1] |=>
        {io_nibble_h_out, io_bitwise_g_out} == $past(avs_writedata[15:8]))
        else $error("paired byte write lost");
    AST_BIT_DIR: assert property (s_wr_done(`PPS_OFS_CMOS_DIR) and avs_byteenable[1] |=>
        {io_bitwise_g_oe, io_bitwise_d_oe} == $past(avs_writedata[15:8]))
        else $error("bit direction not applied");
    AST_OD_PULL: assert property (opendrain_nibble_e_oe == ({4{e_dir_r}} & ~e_r) &&
        opendrain_nibble_f_oe == ({4{f_dir_r}} & ~f_r) && opendrain_nibble_f_out == 4'h0 &&
        opendrain_nibble_e_out == 4'h0)
        else $error("open drain drive wrong");
    AST_SEG_MUX: assert property (s_wr_done(`PPS_OFS_BIT_OUT) and avs_byteenable[1] |=>
        (upper_segment_pins == ($past(avs_writedata[`PPS_SEG_SEL_BIT]) ? seg_data_in : bits_r)))
        else $error("segment handover wrong");
    AST_CMOS_RD: assert property (s_take(`PPS_OFS_CMOS_DATA) and avs_read and
        ({io_nibble_h_oe, io_bitwise_g_oe, io_bitwise_d_oe, io_nibble_c_oe} == 16'h0000) |=>
        avs_readdata[15:0] == $past({io_nibble_h_in, io_bitwise_g_in, io_bitwise_d_in,
        io_nibble_c_in}))
        else $error("cmos lines readback wrong");
    AST_RST_IN: assert property (disable iff (1'b0) !rst_b |->
        {io_nibble_c_oe, io_bitwise_d_oe, io_bitwise_g_oe, io_nibble_h_oe,
        opendrain_nibble_e_oe, opendrain_nibble_f_oe} == 24'h000000)
        else $error("pin driven during reset");
    AST_WAIT_BOUND: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");

endmodule : pps_port_set

// ===== dv/pps_pin_board.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board around the port pins
// ----------------------------------------------------------------
module pps_pin_board (
    input wire logic [31:0] board_val,
    output logic [3:0] a_in,
    output logic [3:0] b_in,
    output logic [3:0] c_in,
    input wire logic [3:0] c_out,
    input wire logic [3:0] c_oe,
    output logic [3:0] d_in,
    input wire logic [3:0] d_out,
    input wire logic [3:0] d_oe,
    output logic [3:0] g_in,
    input wire logic [3:0] g_out,
    input wire logic [3:0] g_oe,
    output logic [3:0] h_in,
    input wire logic [3:0] h_out,
    input wire logic [3:0] h_oe,
    output logic [3:0] e_in,
    input wire logic [3:0] e_out,
    input wire logic [3:0] e_oe,
    output logic [3:0] f_in,
    input wire logic [3:0] f_out,
    input wire logic [3:0] f_oe
);
    // Input-only lines follow the board levels
    assign a_in = board_val[3:0];
    assign b_in = board_val[7:4];
    // CMOS lines: the device wins where it drives, the board elsewhere
    assign c_in = (c_oe & c_out) | (~c_oe & board_val[11:8]);
    assign d_in = (d_oe & d_out) | (~d_oe & board_val[15:12]);
    assign g_in = (g_oe & g_out) | (~g_oe & board_val[19:16]);
    assign h_in = (h_oe & h_out) | (~h_oe & board_val[23:20]);
    // Wired-and with pull-up; a board 0 pulls low whatever the device does
    assign e_in = ~(e_oe & ~e_out) & board_val[27:24];
    assign f_in = ~(f_oe & ~f_out) & board_val[31:28];
endmodule : pps_pin_board

// ===== dv/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port set bench
// ----------------------------------------------------------------
module tb;
    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic [31:0] exp_rd;
    } pps_row_t;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [7:0] seg_data_in = 8'h3C;
    logic [31:0] board_val = 32'h5A3C_96E1;
    logic [31:0] avs_readdata, rd_val;
    logic avs_waitrequest;
    logic [3:0] input_nibble_a_in, input_nibble_b_in;
    logic [3:0] io_nibble_c_in, io_nibble_c_out, io_nibble_c_oe;
    logic [3:0] io_bitwise_d_in, io_bitwise_d_out, io_bitwise_d_oe;
    logic [3:0] io_bitwise_g_in, io_bitwise_g_out, io_bitwise_g_oe;
    logic [3:0] io_nibble_h_in, io_nibble_h_out, io_nibble_h_oe;
    logic [3:0] opendrain_nibble_e_in, opendrain_nibble_e_out, opendrain_nibble_e_oe;
    logic [3:0] opendrain_nibble_f_in, opendrain_nibble_f_out, opendrain_nibble_f_oe;
    logic [7:0] upper_segment_pins;
    int fail_count = 0;
    int tests_run = 0;
    // Write then read back; board levels a=1 b=E c=6 d=9 g=C h=3 e=A f=5
    pps_row_t rows [8] = '{
        '{8'h08, 32'h0000_A503, 4'hF, 32'h0000_A503},
        '{8'h04, 32'h0000_7B2D, 4'hF, 32'h0000_7E8D},
        '{8'h04, 32'h0000_5A00, 4'h2, 32'h0000_5E8D},
        '{8'h10, 32'h0000_0003, 4'hF, 32'h0000_0003},
        '{8'h0C, 32'h0000_006F, 4'hF, 32'h0000_006F},
        '{8'h14, 32'h0000_00A5, 4'hF, 32'h0000_00A5},
        '{8'h00, 32'hFFFF_FFFF, 4'hF, 32'h0000_00E1},
        '{8'h20, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000}
    };

    pps_port_set pps_port_set_i (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .input_nibble_a_in, .input_nibble_b_in, .io_nibble_c_in, .io_nibble_c_out,
        .io_nibble_c_oe, .io_bitwise_d_in, .io_bitwise_d_out, .io_bitwise_d_oe,
        .io_bitwise_g_in, .io_bitwise_g_out, .io_bitwise_g_oe, .io_nibble_h_in,
        .io_nibble_h_out, .io_nibble_h_oe, .opendrain_nibble_e_in, .opendrain_nibble_e_out,
        .opendrain_nibble_e_oe, .opendrain_nibble_f_in, .opendrain_nibble_f_out,
        .opendrain_nibble_f_oe, .seg_data_in, .upper_segment_pins);

    pps_pin_board pps_pin_board_i (.board_val(board_val), .a_in(input_nibble_a_in),
        .b_in(input_nibble_b_in), .c_in(io_nibble_c_in), .c_out(io_nibble_c_out),
        .c_oe(io_nibble_c_oe), .d_in(io_bitwise_d_in), .d_out(io_bitwise_d_out),
        .d_oe(io_bitwise_d_oe), .g_in(io_bitwise_g_in), .g_out(io_bitwise_g_out),
        .g_oe(io_bitwise_g_oe), .h_in(io_nibble_h_in), .h_out(io_nibble_h_out),
        .h_oe(io_nibble_h_oe), .e_in(opendrain_nibble_e_in), .e_out(opendrain_nibble_e_out),
        .e_oe(opendrain_nibble_e_oe), .f_in(opendrain_nibble_f_in),
        .f_out(opendrain_nibble_f_out), .f_oe(opendrain_nibble_f_oe));

    // 125 MHz clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("Counts: checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One Avalon access; waitrequest and readdata sampled at the rising edge,
    // before the design's own update at that edge lands
    task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            input logic [3:0] be, output logic [31:0] rdata);
        logic busy = 1'b1;
        int n = 0;
        @(posedge sys_clk);
        avs_address <= addr;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wdata;
        avs_byteenable <= be;
        while (busy === 1'b1 && n < 20) begin
            @(posedge sys_clk);
            busy = avs_waitrequest;
            rdata = avs_readdata;
            n++;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Outputs launched at the completion edge settle before any compare
        @(negedge sys_clk);
        if (busy !== 1'b0) begin
            fail_count++;
            $display("FAIL bus answer expected 0 seen %b", busy);
            end_of_test();
        end
    endtask : bus_xfer

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Real falling edge so the async reset branch runs at time zero
        rst_b <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check("oe in reset", 32'({io_nibble_c_oe, io_bitwise_d_oe, io_bitwise_g_oe,
            io_nibble_h_oe, opendrain_nibble_e_oe, opendrain_nibble_f_oe}), 32'h0);
        rst_b <= 1'b1;
        bus_xfer(1'b0, 8'h08, 32'h0, 4'hF, rd_val);
        check("dir after reset", rd_val, 32'h0);
        bus_xfer(1'b0, 8'h04, 32'h0, 4'hF, rd_val);
        check("cmos pins as inputs", rd_val, 32'h0000_3C96);
        $display("Test reset done");
        foreach (rows[i]) begin
            bus_xfer(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, rd_val);
            bus_xfer(1'b0, rows[i].addr, 32'h0, 4'hF, rd_val);
            check("row readback", rd_val, rows[i].exp_rd);
        end
        $display("Test table done");
        // Pin drive after the table
        check("c oe", 32'(io_nibble_c_oe), 32'h0000_000F);
        check("c out", 32'(io_nibble_c_out), 32'h0000_000D);
        check("d oe", 32'(io_bitwise_d_oe), 32'h0000_0005);
        check("g oe", 32'(io_bitwise_g_oe), 32'h0000_000A);
        check("g h out", 32'({io_nibble_h_out, io_bitwise_g_out}), 32'h0000_005A);
        check("e oe", 32'(opendrain_nibble_e_oe), 32'h0000_0000);
        check("f oe", 32'(opendrain_nibble_f_oe), 32'h0000_0009);
        check("bit outputs", 32'(upper_segment_pins), 32'h0000_00A5);
        // Hand the bit outputs to the segment driver and back
        bus_xfer(1'b1, 8'h14, 32'h0000_01A5, 4'h3, rd_val);
        check("segment drive", 32'(upper_segment_pins), 32'h0000_003C);
        seg_data_in <= 8'hC3;
        @(negedge sys_clk);
        check("segment follows", 32'(upper_segment_pins), 32'h0000_00C3);
        bus_xfer(1'b1, 8'h14, 32'h0000_0000, 4'h2, rd_val);
        check("port drive back", 32'(upper_segment_pins), 32'h0000_00A5);
        // Open-drain ports turned to input read the pulled-up wire
        bus_xfer(1'b1, 8'h10, 32'h0000_0000, 4'hF, rd_val);
        bus_xfer(1'b0, 8'h0C, 32'h0, 4'hF, rd_val);
        check("open drain pins", rd_val, 32'h0000_005A);
        // Nibble port back to input: all four lines let go together
        bus_xfer(1'b1, 8'h08, 32'h0000_A502, 4'hF, rd_val);
        check("c released", 32'(io_nibble_c_oe), 32'h0000_0000);
        $display("Test pins done");
        // Reset in mid-run with lines driving
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("oe mid reset", 32'({io_bitwise_d_oe, io_bitwise_g_oe, io_nibble_h_oe}),
            32'h0);
        check("bit out mid reset", 32'(upper_segment_pins), 32'h0);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        bus_xfer(1'b0, 8'h14, 32'h0, 4'hF, rd_val);
        check("bit out cleared", rd_val, 32'h0);
        $display("Test second reset done");
        end_of_test();
    end
endmodule : tb
